// ===== rtl/hmp_pkg.sv
/*
  Shared constants, command codes and state types for the internal memory host port.
  Assumes both ends run on the same 40 MHz processor clock and reset.
*/
package hmp_pkg;

  // ----------------------------------------------------------------
  // Widths and memory sizes.
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int ADDR_W = 14;
  localparam int PM_W = 24;
  localparam int MEM_DEPTH = 16384;
  localparam int ADDR_DM_BIT = 14;
  localparam int PM_LOW_W = 8;
  localparam int ENTRY_W = 2 + ADDR_W + DATA_W;

  // ----------------------------------------------------------------
  // Timing, as printed, and the derived cycle counts.
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int LONG_WRITE_MIN_TENTHS_TCK = 15;
  localparam int HOLD_FIRST_MIN_NS = 2 * CLK_PERIOD_NS - 5;
  localparam int HOLD_SECOND_MIN_NS = CLK_PERIOD_NS - 5;
  localparam int WRITE_PULSE_MIN_NS = 15;
  localparam int DATA_SETUP_MIN_NS = 5;
  localparam int DATA_HOLD_MIN_NS = 2;
  localparam int LATCH_MIN_NS = 10;

  function automatic logic [3:0] min_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    min_cycles = (c < 1) ? 4'h1 : c[3:0];
  endfunction

  localparam logic [3:0] LONG_WRITE_CYCLES = 4'((LONG_WRITE_MIN_TENTHS_TCK + 9) / 10);
  localparam logic [3:0] HOLD_FIRST_CYCLES = min_cycles(HOLD_FIRST_MIN_NS);
  localparam logic [3:0] HOLD_SECOND_CYCLES = min_cycles(HOLD_SECOND_MIN_NS);
  localparam logic [3:0] WRITE_PULSE_CYCLES = min_cycles(WRITE_PULSE_MIN_NS);
  localparam logic [3:0] DATA_SETUP_CYCLES = min_cycles(DATA_SETUP_MIN_NS);
  localparam logic [3:0] DATA_HOLD_CYCLES = min_cycles(DATA_HOLD_MIN_NS);
  localparam logic [3:0] LATCH_CYCLES = min_cycles(LATCH_MIN_NS);

  // ----------------------------------------------------------------
  // Commands and states.
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CMD_LATCH = 2'h0,
    CMD_WRITE = 2'h1,
    CMD_READ = 2'h2
  } hmp_cmd_type;

  typedef enum {
    DEV_IDLE, DEV_WR_BUSY, DEV_WR_DONE, DEV_RD_HOLD, DEV_RD_PRESENT, DEV_RD_DONE
  } hmp_dev_state_type;

  typedef enum {
    HOST_IDLE, HOST_SETUP, HOST_STROBE, HOST_WAIT_LOW, HOST_HOLD, HOST_WAIT_BUSY
  } hmp_host_state_type;

endpackage

// ===== rtl/hmp_if.sv
/*
  Pin bundle of the internal memory host port, with one modport for each end.
  Assumes a weak pull-up on the shared bus when neither end drives it.
*/
`timescale 1ns/1ps

interface hmp_if;
  logic port_select_n;
  logic port_write_strobe_n;
  logic port_read_strobe_n;
  logic port_address_latch;
  logic port_acknowledge_n;
  logic [hmp_pkg::DATA_W-1:0] host_bus_out;
  logic host_bus_oe_n;
  logic [hmp_pkg::DATA_W-1:0] dev_bus_out;
  logic dev_bus_oe_n;
  logic [hmp_pkg::DATA_W-1:0] port_addr_data_bus;

  // ----------------------------------------------------------------
  // Level of the shared bus.
  // ----------------------------------------------------------------
  assign port_addr_data_bus = !dev_bus_oe_n ? dev_bus_out :
                              !host_bus_oe_n ? host_bus_out : 16'hffff;

  modport device (
    input port_select_n, port_write_strobe_n, port_read_strobe_n, port_address_latch,
    input port_addr_data_bus,
    output port_acknowledge_n, dev_bus_out, dev_bus_oe_n
  );

  modport host (
    output port_select_n, port_write_strobe_n, port_read_strobe_n, port_address_latch,
    output host_bus_out, host_bus_oe_n,
    input port_acknowledge_n, port_addr_data_bus
  );
endinterface

// ===== rtl/hmp_device.sv
/*
  Device end of the internal memory host port, with its program and data memories.
  Assumes the host keeps its own timing and that core memory use shows on core_mem_busy.
*/
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Two-entry write buffer.
// ------------------------------------------------------------------
module hmp_fifo #(
  parameter int WIDTH = 32
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] slot [0:1];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = slot[rd_ptr];

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= !wr_ptr;
      end
      if (pop) begin
        rd_ptr <= !rd_ptr;
      end
      count <= 2'(count + {1'b0, push} - {1'b0, pop});
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      slot[wr_ptr] <= in_data;
    end
  end
endmodule // hmp_fifo

// ------------------------------------------------------------------
// Device end.
// ------------------------------------------------------------------
module hmp_device (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Link to the host.
  hmp_if.device link,
  // Core side.
  input wire logic core_mem_busy,
  output logic access_done
);
  localparam int SYNC_W = 4 + hmp_pkg::DATA_W;

  logic [SYNC_W-1:0] pin_meta;
  logic [SYNC_W-1:0] pin_sync;
  logic [hmp_pkg::DATA_W-1:0] bus_prev;
  hmp_pkg::hmp_dev_state_type state;
  logic [3:0] cnt;
  logic ack_n;
  logic oe_n;
  logic [hmp_pkg::DATA_W-1:0] bus_out;
  logic [hmp_pkg::DATA_W-1:0] read_word;
  logic [hmp_pkg::DATA_W-1:0] wr_word;
  logic wr_pend;
  logic [hmp_pkg::ADDR_W-1:0] ptr_addr;
  logic ptr_dm;
  logic ptr_half;
  logic [hmp_pkg::DATA_W-1:0] pm_hi;
  logic [hmp_pkg::PM_W-1:0] pm_mem [0:hmp_pkg::MEM_DEPTH-1];
  logic [hmp_pkg::DATA_W-1:0] dm_mem [0:hmp_pkg::MEM_DEPTH-1];
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [hmp_pkg::ENTRY_W-1:0] fifo_out_data;

  // ----------------------------------------------------------------
  // Pin synchronisers and decoded access conditions.
  // ----------------------------------------------------------------
  wire [SYNC_W-1:0] pin_raw = {link.port_select_n, link.port_write_strobe_n,
                               link.port_read_strobe_n, link.port_address_latch,
                               link.port_addr_data_bus};
  wire sel_s = !pin_sync[SYNC_W-1];
  wire [hmp_pkg::DATA_W-1:0] bus_s = pin_sync[hmp_pkg::DATA_W-1:0];
  wire wr_act = sel_s && !pin_sync[SYNC_W-2];
  wire rd_act = sel_s && !pin_sync[SYNC_W-3];
  wire latch_act = sel_s && pin_sync[SYNC_W-4];

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_meta <= {1'b1, 1'b1, 1'b1, 1'b0, 16'hffff};
      pin_sync <= {1'b1, 1'b1, 1'b1, 1'b0, 16'hffff};
      bus_prev <= 16'hffff;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      bus_prev <= bus_s;
    end
  end

  // ----------------------------------------------------------------
  // Write path and fetch decisions.
  // ----------------------------------------------------------------
  wire long_done = (cnt >= hmp_pkg::LONG_WRITE_CYCLES);
  wire [hmp_pkg::DATA_W-1:0] wr_data_now = wr_pend ? wr_word :
                                           (wr_act ? bus_s : bus_prev);
  wire push = (state == hmp_pkg::DEV_WR_BUSY) && long_done && fifo_in_ready;
  wire [hmp_pkg::ENTRY_W-1:0] push_entry = {ptr_dm, ptr_half, ptr_addr, wr_data_now};
  wire [3:0] hold_need = (ptr_dm || !ptr_half) ? hmp_pkg::HOLD_FIRST_CYCLES :
                                                  hmp_pkg::HOLD_SECOND_CYCLES;
  wire fetch_ok = !fifo_out_valid && !core_mem_busy;
  wire fetch = (state == hmp_pkg::DEV_RD_HOLD) && (cnt >= hold_need) && fetch_ok;
  wire [hmp_pkg::PM_W-1:0] pm_word = pm_mem[ptr_addr];
  wire [hmp_pkg::DATA_W-1:0] fetch_data = ptr_dm ? dm_mem[ptr_addr] :
    (ptr_half ? {8'h00, pm_word[hmp_pkg::PM_LOW_W-1:0]} :
                pm_word[hmp_pkg::PM_W-1:hmp_pkg::PM_LOW_W]);
  wire advance = push || fetch;
  wire step_word = ptr_dm || ptr_half;
  wire pop = fifo_out_valid && !core_mem_busy;
  wire pop_dm = fifo_out_data[hmp_pkg::ENTRY_W-1];
  wire pop_half = fifo_out_data[hmp_pkg::ENTRY_W-2];
  wire [hmp_pkg::ADDR_W-1:0] pop_addr = fifo_out_data[hmp_pkg::DATA_W +: hmp_pkg::ADDR_W];
  wire [hmp_pkg::DATA_W-1:0] pop_data = fifo_out_data[hmp_pkg::DATA_W-1:0];
  wire read_state = (state == hmp_pkg::DEV_RD_HOLD) || (state == hmp_pkg::DEV_RD_PRESENT)
                    || (state == hmp_pkg::DEV_RD_DONE);

  hmp_fifo #(
    .WIDTH(hmp_pkg::ENTRY_W)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(push_entry),
    .out_valid(fifo_out_valid),
    .out_ready(!core_mem_busy),
    .out_data(fifo_out_data)
  );

  assign link.port_acknowledge_n = ack_n;
  assign link.dev_bus_oe_n = oe_n;
  assign link.dev_bus_out = bus_out;

  // ----------------------------------------------------------------
  // Access state machine.
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= hmp_pkg::DEV_IDLE;
      cnt <= 4'h0;
      ack_n <= 1'b0;
      oe_n <= 1'b1;
      bus_out <= 16'h0000;
      read_word <= 16'h0000;
      wr_word <= 16'h0000;
      wr_pend <= 1'b0;
      access_done <= 1'b0;
    end else begin
      access_done <= advance;
      if (cnt != 4'hf) begin
        cnt <= 4'(cnt + 4'h1);
      end
      if (read_state && !rd_act) begin
        oe_n <= 1'b1;
      end
      case (state)
        hmp_pkg::DEV_IDLE: begin
          cnt <= 4'h1;
          wr_pend <= 1'b0;
          if (wr_act) begin
            ack_n <= 1'b1;
            state <= hmp_pkg::DEV_WR_BUSY;
          end else if (rd_act) begin
            ack_n <= 1'b1;
            oe_n <= 1'b0;
            bus_out <= read_word;
            state <= hmp_pkg::DEV_RD_HOLD;
          end
        end
        hmp_pkg::DEV_WR_BUSY: begin
          if (!wr_act && !wr_pend) begin
            wr_word <= bus_prev;
            wr_pend <= 1'b1;
          end
          if (push) begin
            ack_n <= 1'b0;
            state <= hmp_pkg::DEV_WR_DONE;
          end
        end
        hmp_pkg::DEV_WR_DONE: begin
          if (!wr_act) begin
            state <= hmp_pkg::DEV_IDLE;
          end
        end
        hmp_pkg::DEV_RD_HOLD: begin
          if (fetch) begin
            read_word <= fetch_data;
            bus_out <= fetch_data;
            state <= hmp_pkg::DEV_RD_PRESENT;
          end
        end
        hmp_pkg::DEV_RD_PRESENT: begin
          ack_n <= 1'b0;
          state <= hmp_pkg::DEV_RD_DONE;
        end
        hmp_pkg::DEV_RD_DONE: begin
          if (!rd_act) begin
            state <= hmp_pkg::DEV_IDLE;
          end
        end
        default: begin
          state <= hmp_pkg::DEV_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Address pointer.
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_addr <= 14'h0000;
      ptr_dm <= 1'b0;
      ptr_half <= 1'b0;
    end else if (latch_act && (state == hmp_pkg::DEV_IDLE)) begin
      ptr_addr <= bus_s[hmp_pkg::ADDR_W-1:0];
      ptr_dm <= bus_s[hmp_pkg::ADDR_DM_BIT];
      ptr_half <= 1'b0;
    end else if (advance) begin
      ptr_half <= !step_word;
      if (step_word) begin
        ptr_addr <= 14'(ptr_addr + 14'h0001);
      end
    end
  end

  // ----------------------------------------------------------------
  // Memory commit from the write buffer.
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      pm_hi <= 16'h0000;
    end else if (pop && !pop_dm && !pop_half) begin
      pm_hi <= pop_data;
    end
  end

  always_ff @(posedge clk) begin
    if (pop && pop_dm) begin
      dm_mem[pop_addr] <= pop_data;
    end
    if (pop && !pop_dm && pop_half) begin
      pm_mem[pop_addr] <= {pm_hi, pop_data[hmp_pkg::PM_LOW_W-1:0]};
    end
  end
endmodule // hmp_device

// ===== rtl/hmp_host.sv
/*
  Host end of the internal memory host port: turns latch, write and read commands into
  pin sequences. Assumes the device end shares the clock.
*/
`timescale 1ns/1ps

module hmp_host (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Link to the device.
  hmp_if.host link,
  // Command side.
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire hmp_pkg::hmp_cmd_type cmd_kind,
  input wire logic [hmp_pkg::DATA_W-1:0] cmd_data,
  // Answer side.
  output logic rsp_valid,
  output logic [hmp_pkg::DATA_W-1:0] rsp_data
);
  logic ack_meta;
  logic ack_s;
  logic [hmp_pkg::DATA_W-1:0] bus_meta;
  logic [hmp_pkg::DATA_W-1:0] bus_s;
  hmp_pkg::hmp_host_state_type state;
  hmp_pkg::hmp_cmd_type kind;
  logic [3:0] cnt;
  logic seen_busy;
  logic sel_n;
  logic wr_n;
  logic rd_n;
  logic latch;
  logic oe_n;
  logic [hmp_pkg::DATA_W-1:0] bus_out;

  assign cmd_ready = (state == hmp_pkg::HOST_IDLE) && !ack_s;
  assign link.port_select_n = sel_n;
  assign link.port_write_strobe_n = wr_n;
  assign link.port_read_strobe_n = rd_n;
  assign link.port_address_latch = latch;
  assign link.host_bus_oe_n = oe_n;
  assign link.host_bus_out = bus_out;

  wire is_read = (kind == hmp_pkg::CMD_READ);
  wire [3:0] pulse_len = (kind == hmp_pkg::CMD_LATCH) ? hmp_pkg::LATCH_CYCLES :
                                                         hmp_pkg::WRITE_PULSE_CYCLES;

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_meta <= 1'b0;
      ack_s <= 1'b0;
      bus_meta <= 16'hffff;
      bus_s <= 16'hffff;
    end else begin
      ack_meta <= link.port_acknowledge_n;
      ack_s <= ack_meta;
      bus_meta <= link.port_addr_data_bus;
      bus_s <= bus_meta;
    end
  end

  // ----------------------------------------------------------------
  // Pin sequencer.
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= hmp_pkg::HOST_IDLE;
      kind <= hmp_pkg::CMD_LATCH;
      cnt <= 4'h0;
      seen_busy <= 1'b0;
      sel_n <= 1'b1;
      wr_n <= 1'b1;
      rd_n <= 1'b1;
      latch <= 1'b0;
      oe_n <= 1'b1;
      bus_out <= 16'h0000;
      rsp_valid <= 1'b0;
      rsp_data <= 16'h0000;
    end else begin
      rsp_valid <= 1'b0;
      if (ack_s) begin
        seen_busy <= 1'b1;
      end
      if (cnt != 4'h0) begin
        cnt <= 4'(cnt - 4'h1);
      end
      case (state)
        hmp_pkg::HOST_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            kind <= cmd_kind;
            bus_out <= cmd_data;
            oe_n <= (cmd_kind == hmp_pkg::CMD_READ);
            seen_busy <= 1'b0;
            cnt <= hmp_pkg::DATA_SETUP_CYCLES;
            state <= hmp_pkg::HOST_SETUP;
          end
        end
        hmp_pkg::HOST_SETUP: begin
          if (cnt <= 4'h1) begin
            sel_n <= 1'b0;
            latch <= (kind == hmp_pkg::CMD_LATCH);
            wr_n <= !(kind == hmp_pkg::CMD_WRITE);
            rd_n <= !is_read;
            cnt <= pulse_len;
            state <= is_read ? hmp_pkg::HOST_WAIT_LOW : hmp_pkg::HOST_STROBE;
          end
        end
        hmp_pkg::HOST_STROBE: begin
          if (cnt <= 4'h1) begin
            sel_n <= 1'b1;
            wr_n <= 1'b1;
            latch <= 1'b0;
            cnt <= hmp_pkg::DATA_HOLD_CYCLES;
            state <= hmp_pkg::HOST_HOLD;
          end
        end
        hmp_pkg::HOST_WAIT_LOW: begin
          if ((seen_busy || ack_s) && !ack_s) begin
            rsp_data <= bus_s;
            rsp_valid <= 1'b1;
            sel_n <= 1'b1;
            rd_n <= 1'b1;
            cnt <= hmp_pkg::DATA_HOLD_CYCLES;
            state <= hmp_pkg::HOST_HOLD;
          end
        end
        hmp_pkg::HOST_HOLD: begin
          if (cnt <= 4'h1) begin
            oe_n <= 1'b1;
            state <= (kind == hmp_pkg::CMD_WRITE) ? hmp_pkg::HOST_WAIT_BUSY :
                                                     hmp_pkg::HOST_IDLE;
          end
        end
        hmp_pkg::HOST_WAIT_BUSY: begin
          if (seen_busy && !ack_s) begin
            state <= hmp_pkg::HOST_IDLE;
          end
        end
        default: begin
          state <= hmp_pkg::HOST_IDLE;
        end
      endcase
    end
  end
endmodule // hmp_host

// ===== test/hmp_props.sv
/*
  Concurrent checks on the pins of the internal memory host port.
  Assumes one clock and a synchronous active-high reset shared by both ends.
*/
`timescale 1ns/1ps

module hmp_props (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Host strobes.
  input wire logic port_select_n,
  input wire logic port_write_strobe_n,
  input wire logic port_read_strobe_n,
  input wire logic port_address_latch,
  // Device answer.
  input wire logic port_acknowledge_n,
  // Bus halves and resolved bus.
  input wire logic [hmp_pkg::DATA_W-1:0] host_bus_out,
  input wire logic host_bus_oe_n,
  input wire logic [hmp_pkg::DATA_W-1:0] dev_bus_out,
  input wire logic dev_bus_oe_n,
  input wire logic [hmp_pkg::DATA_W-1:0] port_addr_data_bus
);
  // ----------------------------------------------------------------
  // Access decoding.
  // ----------------------------------------------------------------
  wire wr_act = !port_select_n && !port_write_strobe_n;
  wire rd_act = !port_select_n && !port_read_strobe_n;
  wire latch_act = !port_select_n && port_address_latch;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_wr_start;
    $rose(wr_act);
  endsequence

  sequence s_rd_start;
    $rose(rd_act);
  endsequence

  sequence s_ack_busy;
    ##[1:4] port_acknowledge_n;
  endsequence

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  a_wr_ack_rise: assert property (s_wr_start |-> s_ack_busy)
    else $error("acknowledge not raised after write start");
  a_long_wr_min: assert property (s_wr_start |-> ##1 (!$fell(port_acknowledge_n)) [*2])
    else $error("acknowledge dropped too early in write");
  a_rd_ack_rise: assert property (s_rd_start |-> s_ack_busy)
    else $error("acknowledge not raised after read start");
  a_rd_drive_prev: assert property (s_rd_start |-> ##[1:4] !dev_bus_oe_n)
    else $error("device did not drive bus on read");
  a_rd_release: assert property ($fell(rd_act) |-> ##[1:4] dev_bus_oe_n)
    else $error("device kept bus after read end");
  a_data_before_ack: assert property ($fell(port_acknowledge_n) && !dev_bus_oe_n |->
    $stable(dev_bus_out) && $past(!dev_bus_oe_n))
    else $error("read data not settled before acknowledge low");
  a_ack_held_low: assert property (!port_acknowledge_n && port_select_n && $past(port_select_n)
    && $past(port_select_n, 2) |=> !port_acknowledge_n)
    else $error("acknowledge rose without an access");
  a_wr_after_ready: assert property (s_wr_start |-> !port_acknowledge_n)
    else $error("write began while busy");
  a_rd_after_ready: assert property (s_rd_start |-> !port_acknowledge_n)
    else $error("read began while busy");
  a_wr_data_hold: assert property ($fell(wr_act) |-> !host_bus_oe_n && $stable(host_bus_out)
    && $past(!host_bus_oe_n, 2))
    else $error("write data not held around write end");
  a_latch_addr: assert property ($rose(latch_act) |-> !host_bus_oe_n ##1
    (!host_bus_oe_n && $stable(host_bus_out)))
    else $error("address not held around latch");
endmodule // hmp_props

// ===== test/tb_host_memory_access_port_rw.sv
/*
  Self-checking bench: host and device ends joined by one interface, commands from a
  table, then buffer-full, stall and reset cases. Assumes package and design compiled first.
*/
`timescale 1ns/1ps

module tb_host_memory_access_port_rw;
  typedef struct packed {
    hmp_pkg::hmp_cmd_type kind;
    logic [hmp_pkg::DATA_W-1:0] data;
    logic [hmp_pkg::DATA_W-1:0] exp;
  } hmp_row_type;

  logic clk;
  logic rst;
  logic core_mem_busy;
  logic access_done;
  logic cmd_valid;
  logic cmd_ready;
  hmp_pkg::hmp_cmd_type cmd_kind;
  logic [hmp_pkg::DATA_W-1:0] cmd_data;
  logic rsp_valid;
  logic [hmp_pkg::DATA_W-1:0] rsp_data;
  int n_errors = 0;
  int samples_checked = 0;
  int done_count = 0;
  int done_exp = 0;
  hmp_row_type rows [12];

  // ----------------------------------------------------------------
  // Both ends and the checker.
  // ----------------------------------------------------------------
  hmp_if link_if ();
  hmp_device hmp_device_inst (.clk(clk), .rst(rst), .link(link_if),
    .core_mem_busy(core_mem_busy), .access_done(access_done));
  hmp_host hmp_host_inst (.clk(clk), .rst(rst), .link(link_if), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  hmp_props hmp_props_inst (.clk(clk), .rst(rst), .port_select_n(link_if.port_select_n),
    .port_write_strobe_n(link_if.port_write_strobe_n),
    .port_read_strobe_n(link_if.port_read_strobe_n),
    .port_address_latch(link_if.port_address_latch),
    .port_acknowledge_n(link_if.port_acknowledge_n), .host_bus_out(link_if.host_bus_out),
    .host_bus_oe_n(link_if.host_bus_oe_n), .dev_bus_out(link_if.dev_bus_out),
    .dev_bus_oe_n(link_if.dev_bus_oe_n), .port_addr_data_bus(link_if.port_addr_data_bus));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(negedge clk) begin
    if (rst === 1'b0 && access_done === 1'b1) begin
      done_count++;
    end
  end

  // ----------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("Checks made: %0d, mismatches: %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check_word(input logic [hmp_pkg::DATA_W-1:0] got,
                            input logic [hmp_pkg::DATA_W-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_up();
    n_errors++;
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    conclude();
  endtask

  task automatic do_cmd(input hmp_pkg::hmp_cmd_type kind,
                        input logic [hmp_pkg::DATA_W-1:0] data);
    int i;
    i = 0;
    do begin
      @(posedge clk);
      #1;
      i++;
      if (i > 400) give_up();
    end while (cmd_ready !== 1'b1);
    cmd_kind = kind;
    cmd_data = data;
    cmd_valid = 1'b1;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    if (kind != hmp_pkg::CMD_LATCH) done_exp++;
  endtask

  task automatic wait_rsp(output logic [hmp_pkg::DATA_W-1:0] got);
    int i;
    i = 0;
    do begin
      @(posedge clk);
      #1;
      i++;
      if (i > 400) give_up();
    end while (rsp_valid !== 1'b1);
    got = rsp_data;
  endtask

  task automatic wait_drive(output logic [hmp_pkg::DATA_W-1:0] got);
    int i;
    i = 0;
    while (!(link_if.dev_bus_oe_n === 1'b0 && link_if.port_acknowledge_n === 1'b1)) begin
      @(posedge clk);
      #1;
      i++;
      if (i > 400) give_up();
    end
    got = link_if.port_addr_data_bus;
  endtask

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    logic [hmp_pkg::DATA_W-1:0] got;
    logic [hmp_pkg::DATA_W-1:0] last_word;
    logic prev_read;
    logic seen;
    rst = 1'b1;
    core_mem_busy = 1'b0;
    cmd_valid = 1'b0;
    cmd_kind = hmp_pkg::CMD_LATCH;
    cmd_data = 16'h0000;
    rows[0] = '{hmp_pkg::CMD_LATCH, 16'h4010, 16'h0000};
    rows[1] = '{hmp_pkg::CMD_WRITE, 16'h1234, 16'h0000};
    rows[2] = '{hmp_pkg::CMD_WRITE, 16'habcd, 16'h0000};
    rows[3] = '{hmp_pkg::CMD_LATCH, 16'h0020, 16'h0000};
    rows[4] = '{hmp_pkg::CMD_WRITE, 16'hbeef, 16'h0000};
    rows[5] = '{hmp_pkg::CMD_WRITE, 16'hff55, 16'h0000};
    rows[6] = '{hmp_pkg::CMD_LATCH, 16'h4010, 16'h0000};
    rows[7] = '{hmp_pkg::CMD_READ, 16'h0000, 16'h1234};
    rows[8] = '{hmp_pkg::CMD_READ, 16'h0000, 16'habcd};
    rows[9] = '{hmp_pkg::CMD_LATCH, 16'h0020, 16'h0000};
    rows[10] = '{hmp_pkg::CMD_READ, 16'h0000, 16'hbeef};
    rows[11] = '{hmp_pkg::CMD_READ, 16'h0000, 16'h0055};
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    check_bit(link_if.port_acknowledge_n, 1'b0);
    check_bit(link_if.dev_bus_oe_n, 1'b1);
    check_bit(link_if.port_select_n, 1'b1);
    prev_read = 1'b0;
    last_word = 16'h0000;
    for (int k = 0; k < 12; k++) begin
      do_cmd(rows[k].kind, rows[k].data);
      if (rows[k].kind == hmp_pkg::CMD_READ) begin
        wait_drive(got);
        if (prev_read) check_word(got, last_word);
        wait_rsp(got);
        check_word(got, rows[k].exp);
        last_word = rows[k].exp;
      end
      prev_read = (rows[k].kind == hmp_pkg::CMD_READ);
    end
    // Buffer full: the third write must stay unacknowledged while memory is stalled.
    core_mem_busy = 1'b1;
    do_cmd(hmp_pkg::CMD_LATCH, 16'h4030);
    for (int j = 0; j < 3; j++) do_cmd(hmp_pkg::CMD_WRITE, 16'h0a01 + 16'(j));
    repeat (20) @(posedge clk);
    #1;
    check_bit(link_if.port_acknowledge_n, 1'b1);
    check_bit(cmd_ready, 1'b0);
    core_mem_busy = 1'b0;
    do_cmd(hmp_pkg::CMD_LATCH, 16'h4030);
    core_mem_busy = 1'b1;
    do_cmd(hmp_pkg::CMD_READ, 16'h0000);
    seen = 1'b0;
    repeat (30) begin
      @(posedge clk);
      #1;
      if (rsp_valid === 1'b1) seen = 1'b1;
    end
    check_bit(seen, 1'b0);
    check_bit(link_if.port_acknowledge_n, 1'b1);
    core_mem_busy = 1'b0;
    wait_rsp(got);
    check_word(got, 16'h0a01);
    for (int j = 1; j < 3; j++) begin
      do_cmd(hmp_pkg::CMD_READ, 16'h0000);
      wait_rsp(got);
      check_word(got, 16'h0a01 + 16'(j));
    end
    repeat (10) @(posedge clk);
    #1;
    check_word(16'(done_count), 16'(done_exp));
    // Reset in mid-run, then a read showing the cleared previous word.
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    check_bit(link_if.port_acknowledge_n, 1'b0);
    check_bit(rsp_valid, 1'b0);
    do_cmd(hmp_pkg::CMD_LATCH, 16'h4010);
    do_cmd(hmp_pkg::CMD_READ, 16'h0000);
    wait_drive(got);
    check_word(got, 16'h0000);
    wait_rsp(got);
    check_word(got, 16'h1234);
    repeat (5) @(posedge clk);
    conclude();
  end

  initial begin
    repeat (90000) @(posedge clk);
    give_up();
  end
endmodule // tb_host_memory_access_port_rw
